// ===== hdl/viom_defines.vh
// Constants for the virtual I/O mapper: register word addresses,
// field widths, reset values, analog thresholds and timing figures.
// Assumes a 40 MHz core clock and analog samples in signed millivolts.
`ifndef VIOM_DEFINES_VH
`define VIOM_DEFINES_VH

// Counts and widths
`define VIOM_NUM_VIN        5
`define VIOM_NUM_VOUT       5
`define VIOM_NUM_AIN        3
`define VIOM_FUNC_W         6
`define VIOM_NUM_DI_FUNC    60
`define VIOM_NUM_DO_FUNC    41
`define VIOM_DELAY_W        16
`define VIOM_AIN_W          16
`define VIOM_ADDR_W         8
`define VIOM_DATA_W         32

// Function code limits and special codes
`define VIOM_DI_FUNC_MAX    32'h0000003B
`define VIOM_DO_FUNC_MAX    32'h00000028
`define VIOM_DELAY_MAX      32'h00008CA0
`define VIOM_FN_FWD_RUN     6'h01
`define VIOM_FN_USER_FAULT1 6'h2C
`define VIOM_FN_AIN1_LIMIT  6'h1F
`define VIOM_FAULT_CODE     8'h1B
`define VIOM_CMD_SRC_TERM   2'h1

// Register word addresses
`define VIOM_A_VIN_FUNC0    8'h00
`define VIOM_A_VIN_SRC      8'h05
`define VIOM_A_VIN_FORCE    8'h06
`define VIOM_A_AIN_FUNC0    8'h07
`define VIOM_A_AIN_POL      8'h0A
`define VIOM_A_VOUT_FUNC0   8'h0B
`define VIOM_A_VOUT_DLY0    8'h10
`define VIOM_A_VOUT_SEL     8'h15
`define VIOM_A_CMD_SRC      8'h20
`define VIOM_A_START_PROT   8'h21
`define VIOM_A_AIN1_LIMIT   8'h22
`define VIOM_A_STATUS       8'h23
`define VIOM_A_FAULT        8'h24

// Status register field positions
`define VIOM_ST_VIN_LSB     0
`define VIOM_ST_VOUT_LSB    8
`define VIOM_ST_AIN_LSB     16
`define VIOM_ST_FAULT_BIT   24
`define VIOM_ST_RUN_BIT     25

// Reset values
`define VIOM_RST_FUNC       6'h00
`define VIOM_RST_MASK5      5'h00
`define VIOM_RST_MASK3      3'h0
`define VIOM_RST_DELAY      16'h0000
`define VIOM_RST_CMD_SRC    2'h0
`define VIOM_RST_AIN1_LIMIT 16'h2710

// Analog-as-digital thresholds, millivolts
`define VIOM_AIN_HIGH_MV    16'sd7000
`define VIOM_AIN_LOW_MV     16'sd3000

// Timing: core clock period and delay tick, both in ns
`define VIOM_CLK_NS         25
`define VIOM_TICK_NS        100000000

`endif

// ===== hdl/viom_hyst.v
// One analog input turned into a digital level with hysteresis.
// Assumes samples arrive synchronous to core_clk as signed millivolts.
`timescale 1ns/1ps
`include "viom_defines.vh"

module viom_hyst (
	// Clock and reset
	input  wire                          core_clk,
	input  wire                          reset,
	// Analog sample
	input  wire signed [`VIOM_AIN_W-1:0] sample_mv,
	// Digital level
	output reg                           level_q
);

	// Level holds between thresholds, so noise near mid-scale never chatters
	always @(posedge core_clk) begin
		if (reset) begin
			level_q <= 1'b0;
		end else if (sample_mv >= `VIOM_AIN_HIGH_MV) begin
			level_q <= 1'b1;
		end else if (sample_mv <= `VIOM_AIN_LOW_MV) begin
			level_q <= 1'b0;
		end
	end

endmodule

// ===== hdl/viom_delay.v
// Output delay for one virtual output, counted in 0.1 s ticks.
// Assumes tick is a one-cycle pulse every 0.1 s from the top level.
`timescale 1ns/1ps
`include "viom_defines.vh"

module viom_delay (
	// Clock and reset
	input  wire                     core_clk,
	input  wire                     reset,
	// Timebase
	input  wire                     tick,
	// Condition and delay setting
	input  wire                     cond,
	input  wire [`VIOM_DELAY_W-1:0] delay,
	// Delayed state
	output reg                      out_q
);

	reg [`VIOM_DELAY_W-1:0] cnt_q; // Ticks since the condition changed

	// Count restarts whenever the condition returns to the output state.
	// The first tick may come early, so the delay is short by < 0.1 s.
	always @(posedge core_clk) begin
		if (reset) begin
			out_q <= 1'b0;
			cnt_q <= `VIOM_RST_DELAY;
		end else if (cond == out_q) begin
			cnt_q <= `VIOM_RST_DELAY;
		end else if (delay == `VIOM_RST_DELAY) begin
			out_q <= cond;
		end else if (tick) begin
			if (cnt_q + 16'h0001 >= delay) begin
				out_q <= cond;
				cnt_q <= `VIOM_RST_DELAY;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

endmodule

// ===== hdl/viom_top.v
// Virtual I/O mapper: virtual inputs, analog inputs used as digital
// inputs, and delayed virtual outputs, with a plain register port.
// Assumes all inputs are synchronous to core_clk; the dispatcher reads
// the active function vector and supplies output function states.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "viom_defines.vh"

// Overview of operation
// - Five virtual inputs, function codes 0 to 59
// - Per-input source: bound output or forced setting
// - Forced source follows its own forced-state bit
// - Bound source takes same-numbered virtual output
// - After init, forward run from terminal command
// - Function 44 active raises user fault, stops
// - Three analog inputs take digital functions 0-59
// - Analog high at 7 V, low at 3 V
// - Per-analog polarity: high or low active
// - Five virtual outputs, functions 0-40, delays
// - Function 0 mirrors same-index physical input
// - Nonzero function follows output function definitions
// - Per-output state select bit, default zero
// - Function 31 on while analog one exceeds limit
module viom_top #(
	parameter TICK_CYCLES = `VIOM_TICK_NS / `VIOM_CLK_NS
) (
	// Clock and reset
	input  wire                           core_clk,
	input  wire                           reset,
	// Register port
	input  wire [`VIOM_ADDR_W-1:0]        reg_addr,
	input  wire [`VIOM_DATA_W-1:0]        reg_wdata,
	input  wire                           reg_wr,
	input  wire                           reg_rd,
	output reg  [`VIOM_DATA_W-1:0]        reg_rdata_q,
	// Physical terminals and analog samples
	input  wire [`VIOM_NUM_VOUT-1:0]      physical_input_n,
	input  wire signed [`VIOM_AIN_W-1:0]  analog_in_one,
	input  wire signed [`VIOM_AIN_W-1:0]  analog_in_two,
	input  wire signed [`VIOM_AIN_W-1:0]  analog_in_three,
	// Drive dispatcher
	input  wire                           init_done,
	input  wire [`VIOM_NUM_DO_FUNC-1:0]   do_function_state,
	output reg  [`VIOM_NUM_DI_FUNC-1:0]   di_function_active_q,
	output reg                            forward_run_q,
	output reg                            fault_active_q,
	output reg  [7:0]                     fault_code_q,
	output reg  [`VIOM_NUM_VOUT-1:0]      virtual_output_q
);

	// Configuration registers
	reg [`VIOM_FUNC_W-1:0]  vin_func_q [0:`VIOM_NUM_VIN-1];   // Input functions
	reg [`VIOM_FUNC_W-1:0]  ain_func_q [0:`VIOM_NUM_AIN-1];   // Analog functions
	reg [`VIOM_FUNC_W-1:0]  vout_func_q [0:`VIOM_NUM_VOUT-1]; // Output functions
	reg [`VIOM_DELAY_W-1:0] vout_dly_q [0:`VIOM_NUM_VOUT-1];  // Output delays
	reg [`VIOM_NUM_VIN-1:0]  virtual_input_source_mode_q;     // 1 = forced
	reg [`VIOM_NUM_VIN-1:0]  virtual_input_forced_state_q;    // Forced levels
	reg [`VIOM_NUM_AIN-1:0]  analog_as_digital_polarity_q;    // 1 = low active
	reg [`VIOM_NUM_VOUT-1:0] virtual_output_state_select_q;   // 1 = inverted
	reg [1:0]                command_source_select_q;         // Run source
	reg                      startup_protection_q;            // Start guard
	reg [`VIOM_AIN_W-1:0]    ain1_limit_q;                    // mV limit

	// Block state
	reg [`VIOM_NUM_VIN-1:0]  virtual_input_q;  // Resolved input states
	reg                      limit_exceeded_q; // Analog one over limit
	reg                      fault_seen_q;     // Previous fault-1 level
	reg                      run_block_q;      // Start guard active
	reg [22:0]               tick_cnt_q;       // Tick prescaler
	reg                      tick_q;           // 0.1 s pulse

	// Combinational terms
	wire [`VIOM_NUM_AIN-1:0]  ain_level;  // Hysteresis outputs
	wire [`VIOM_NUM_VOUT-1:0] vout_state; // Delayed outputs
	reg  [`VIOM_NUM_AIN-1:0]  ain_active; // Level after polarity
	reg  [`VIOM_NUM_VOUT-1:0] vout_cond;  // Undelayed output conditions
	reg  [`VIOM_NUM_VIN-1:0]  vin_d;      // Next virtual input states
	reg  [`VIOM_NUM_DI_FUNC-1:0] di_d;    // Next active function vector
	wire                      fwd_req;    // Forward run asserted
	wire                      fault_req;  // User fault one asserted
	wire                      fault_clr;  // Software fault clear
	wire                      fault_set;  // Fault rising edge
	wire signed [`VIOM_AIN_W-1:0] ain_bus [0:`VIOM_NUM_AIN-1]; // Samples
	integer                   i;          // Write loop index
	integer                   j;          // Read loop index
	integer                   k;          // Select loop index
	integer                   m;          // Vector loop index
	integer                   c;          // Function code index

	assign ain_bus[0] = analog_in_one;
	assign ain_bus[1] = analog_in_two;
	assign ain_bus[2] = analog_in_three;

	// True when a write value stays within its documented range
	function in_range;
		input [`VIOM_DATA_W-1:0] value;
		input [`VIOM_DATA_W-1:0] max;
		begin
			in_range = (value <= max);
		end
	endfunction

	// Word address of channel n counted from a base address
	function [`VIOM_ADDR_W-1:0] chan_addr;
		input [`VIOM_ADDR_W-1:0] base;
		input integer            n;
		begin
			chan_addr = base + n[`VIOM_ADDR_W-1:0];
		end
	endfunction

	// Analog inputs through hysteresis comparators
	genvar g;
	generate
		for (g = 0; g < `VIOM_NUM_AIN; g = g + 1) begin : g_ain
			viom_hyst u_hyst (
				.core_clk  (core_clk),
				.reset     (reset),
				.sample_mv (ain_bus[g]),
				.level_q   (ain_level[g])
			);
		end
	endgenerate

	// Virtual outputs through per-channel delay counters
	generate
		for (g = 0; g < `VIOM_NUM_VOUT; g = g + 1) begin : g_vout
			viom_delay u_delay (
				.core_clk (core_clk),
				.reset    (reset),
				.tick     (tick_q),
				.cond     (vout_cond[g]),
				.delay    (vout_dly_q[g]),
				.out_q    (vout_state[g])
			);
		end
	endgenerate

	// Register writes; out-of-range function codes and delays are dropped, old value kept; other fields keep their low bits
	always @(posedge core_clk) begin
		if (reset) begin
			for (i = 0; i < `VIOM_NUM_VIN; i = i + 1) begin
				vin_func_q[i] <= `VIOM_RST_FUNC;
			end
			for (i = 0; i < `VIOM_NUM_AIN; i = i + 1) begin
				ain_func_q[i] <= `VIOM_RST_FUNC;
			end
			for (i = 0; i < `VIOM_NUM_VOUT; i = i + 1) begin
				vout_func_q[i] <= `VIOM_RST_FUNC;
				vout_dly_q[i]  <= `VIOM_RST_DELAY;
			end
			virtual_input_source_mode_q   <= `VIOM_RST_MASK5;
			virtual_input_forced_state_q  <= `VIOM_RST_MASK5;
			analog_as_digital_polarity_q  <= `VIOM_RST_MASK3;
			virtual_output_state_select_q <= `VIOM_RST_MASK5;
			command_source_select_q       <= `VIOM_RST_CMD_SRC;
			startup_protection_q          <= 1'b0;
			ain1_limit_q                  <= `VIOM_RST_AIN1_LIMIT;
		end else if (reg_wr) begin
			for (i = 0; i < `VIOM_NUM_VIN; i = i + 1) begin
				// Input functions, 0 to 59
				if (reg_addr == chan_addr(`VIOM_A_VIN_FUNC0, i) &&
				    in_range(reg_wdata, `VIOM_DI_FUNC_MAX)) begin
					vin_func_q[i] <= reg_wdata[`VIOM_FUNC_W-1:0];
				end
			end
			for (i = 0; i < `VIOM_NUM_AIN; i = i + 1) begin
				// Analog functions, 0 to 59
				if (reg_addr == chan_addr(`VIOM_A_AIN_FUNC0, i) &&
				    in_range(reg_wdata, `VIOM_DI_FUNC_MAX)) begin
					ain_func_q[i] <= reg_wdata[`VIOM_FUNC_W-1:0];
				end
			end
			for (i = 0; i < `VIOM_NUM_VOUT; i = i + 1) begin
				// Output functions 0 to 40, delays up to 3600.0 s
				if (reg_addr == chan_addr(`VIOM_A_VOUT_FUNC0, i) &&
				    in_range(reg_wdata, `VIOM_DO_FUNC_MAX)) begin
					vout_func_q[i] <= reg_wdata[`VIOM_FUNC_W-1:0];
				end
				if (reg_addr == chan_addr(`VIOM_A_VOUT_DLY0, i) &&
				    in_range(reg_wdata, `VIOM_DELAY_MAX)) begin
					vout_dly_q[i] <= reg_wdata[`VIOM_DELAY_W-1:0];
				end
			end
			case (reg_addr)
				`VIOM_A_VIN_SRC: begin
					virtual_input_source_mode_q <= reg_wdata[4:0];
				end
				`VIOM_A_VIN_FORCE: begin
					virtual_input_forced_state_q <= reg_wdata[4:0];
				end
				`VIOM_A_AIN_POL: begin
					analog_as_digital_polarity_q <= reg_wdata[2:0];
				end
				`VIOM_A_VOUT_SEL: begin
					virtual_output_state_select_q <= reg_wdata[4:0];
				end
				`VIOM_A_CMD_SRC: begin
					command_source_select_q <= reg_wdata[1:0];
				end
				`VIOM_A_START_PROT: begin
					startup_protection_q <= reg_wdata[0];
				end
				`VIOM_A_AIN1_LIMIT: begin
					ain1_limit_q <= reg_wdata[`VIOM_AIN_W-1:0];
				end
				default: begin
					// Unmapped or read-only word, write ignored
				end
			endcase
		end
	end

	// Read data, registered in the cycle after the strobe and held until the next read
	always @(posedge core_clk) begin
		if (reset) begin
			reg_rdata_q <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata_q <= 32'h00000000; // Unmapped reads as zero
			for (j = 0; j < `VIOM_NUM_VIN; j = j + 1) begin
				if (reg_addr == chan_addr(`VIOM_A_VIN_FUNC0, j)) begin
					reg_rdata_q[5:0] <= vin_func_q[j];
				end
			end
			for (j = 0; j < `VIOM_NUM_AIN; j = j + 1) begin
				if (reg_addr == chan_addr(`VIOM_A_AIN_FUNC0, j)) begin
					reg_rdata_q[5:0] <= ain_func_q[j];
				end
			end
			for (j = 0; j < `VIOM_NUM_VOUT; j = j + 1) begin
				if (reg_addr == chan_addr(`VIOM_A_VOUT_FUNC0, j)) begin
					reg_rdata_q[5:0] <= vout_func_q[j];
				end
				if (reg_addr == chan_addr(`VIOM_A_VOUT_DLY0, j)) begin
					reg_rdata_q[15:0] <= vout_dly_q[j];
				end
			end
			case (reg_addr)
				`VIOM_A_VIN_SRC: begin
					reg_rdata_q[4:0] <= virtual_input_source_mode_q;
				end
				`VIOM_A_VIN_FORCE: begin
					reg_rdata_q[4:0] <= virtual_input_forced_state_q;
				end
				`VIOM_A_AIN_POL: begin
					reg_rdata_q[2:0] <= analog_as_digital_polarity_q;
				end
				`VIOM_A_VOUT_SEL: begin
					reg_rdata_q[4:0] <= virtual_output_state_select_q;
				end
				`VIOM_A_CMD_SRC: begin
					reg_rdata_q[1:0] <= command_source_select_q;
				end
				`VIOM_A_START_PROT: begin
					reg_rdata_q[0] <= startup_protection_q;
				end
				`VIOM_A_AIN1_LIMIT: begin
					reg_rdata_q[15:0] <= ain1_limit_q;
				end
				`VIOM_A_STATUS: begin
					// Live block state for software
					reg_rdata_q[`VIOM_ST_VIN_LSB +: 5]  <= virtual_input_q;
					reg_rdata_q[`VIOM_ST_VOUT_LSB +: 5] <= virtual_output_q;
					reg_rdata_q[`VIOM_ST_AIN_LSB +: 3]  <= ain_active;
					reg_rdata_q[`VIOM_ST_FAULT_BIT]     <= fault_active_q;
					reg_rdata_q[`VIOM_ST_RUN_BIT]       <= forward_run_q;
				end
				`VIOM_A_FAULT: begin
					reg_rdata_q[7:0] <= fault_code_q;
				end
				default: begin
					// Keep zero
				end
			endcase
		end
	end

	// Polarity, input source selection and output conditions
	always @* begin
		for (k = 0; k < `VIOM_NUM_AIN; k = k + 1) begin
			ain_active[k] = ain_level[k] ^
			                analog_as_digital_polarity_q[k];
		end
		for (k = 0; k < `VIOM_NUM_VIN; k = k + 1) begin
			if (virtual_input_source_mode_q[k]) begin
				vin_d[k] = virtual_input_forced_state_q[k];
			end else begin
				vin_d[k] = virtual_output_q[k];
			end
		end
		for (k = 0; k < `VIOM_NUM_VOUT; k = k + 1) begin
			if (vout_func_q[k] == `VIOM_RST_FUNC) begin
				vout_cond[k] = physical_input_n[k];
			end else if (vout_func_q[k] == `VIOM_FN_AIN1_LIMIT) begin
				vout_cond[k] = limit_exceeded_q;
			end else begin
				vout_cond[k] = do_function_state[vout_func_q[k]];
			end
			vout_cond[k] = vout_cond[k] ^
			               virtual_output_state_select_q[k];
		end
	end

	// Function vector: code 0 means no function and never asserts
	always @* begin
		di_d = {`VIOM_NUM_DI_FUNC{1'b0}};
		for (c = 1; c < `VIOM_NUM_DI_FUNC; c = c + 1) begin
			for (m = 0; m < `VIOM_NUM_VIN; m = m + 1) begin
				if (virtual_input_q[m] && vin_func_q[m] == c) begin
					di_d[c] = 1'b1;
				end
			end
			for (m = 0; m < `VIOM_NUM_AIN; m = m + 1) begin
				if (ain_active[m] && ain_func_q[m] == c) begin
					di_d[c] = 1'b1;
				end
			end
		end
	end

	assign fwd_req   = di_function_active_q[`VIOM_FN_FWD_RUN];
	assign fault_req = di_function_active_q[`VIOM_FN_USER_FAULT1];
	assign fault_set = fault_req & ~fault_seen_q;
	assign fault_clr = reg_wr && reg_addr == `VIOM_A_FAULT && reg_wdata[0];

	// Tick prescaler, one pulse each 0.1 s
	always @(posedge core_clk) begin
		if (reset) begin
			tick_cnt_q <= 23'h000000;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TICK_CYCLES - 1) begin
			tick_cnt_q <= 23'h000000;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 23'h000001;
			tick_q     <= 1'b0;
		end
	end

	// State registers and dispatcher outputs
	always @(posedge core_clk) begin
		if (reset) begin
			virtual_input_q      <= `VIOM_RST_MASK5;
			virtual_output_q     <= `VIOM_RST_MASK5;
			di_function_active_q <= {`VIOM_NUM_DI_FUNC{1'b0}};
			limit_exceeded_q     <= 1'b0;
			fault_seen_q         <= 1'b0;
			fault_active_q       <= 1'b0;
			fault_code_q         <= 8'h00;
			run_block_q          <= 1'b1;
			forward_run_q        <= 1'b0;
		end else begin
			virtual_input_q      <= vin_d;
			virtual_output_q     <= vout_state;
			di_function_active_q <= di_d;
			limit_exceeded_q     <= analog_in_one >
			                        $signed(ain1_limit_q);
			fault_seen_q         <= fault_req;
			// New fault edge wins over a clear in the same cycle
			if (fault_set) begin
				fault_active_q <= 1'b1;
				fault_code_q   <= `VIOM_FAULT_CODE;
			end else if (fault_clr) begin
				fault_active_q <= 1'b0;
				fault_code_q   <= 8'h00;
			end
			// Start guard: a run command held through init is refused
			// until it drops, when protection is on
			if (!init_done) begin
				run_block_q <= 1'b1;
			end else if (!startup_protection_q || !fwd_req) begin
				run_block_q <= 1'b0;
			end
			forward_run_q <= init_done && !run_block_q && fwd_req &&
			                 command_source_select_q ==
			                 `VIOM_CMD_SRC_TERM &&
			                 !fault_active_q && !fault_set;
		end
	end

endmodule

// ===== sim/viom_top_sva.sv
// Checker for the virtual I/O mapper top level, bound to its ports.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "viom_defines.vh"

module viom_top_sva #(
	parameter TICK_CYCLES = 4
) (
	// Clock and reset
	input wire        core_clk,
	input wire        reset,
	// Register port
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata_q,
	// Dispatcher side
	input wire        init_done,
	input wire [59:0] di_function_active_q,
	input wire        forward_run_q,
	input wire        fault_active_q,
	input wire [7:0]  fault_code_q
);
	// Every check shares the core clock and reset
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	fault_code_a: assert property (
		fault_code_q == (fault_active_q ? `VIOM_FAULT_CODE : 8'h00))
		else $error("fault code does not track fault state");
	fault_stop_a: assert property (
		fault_active_q |-> !forward_run_q)
		else $error("forward run present while fault latched");
	fault_set_a: assert property (
		$rose(di_function_active_q[44]) |=> fault_active_q)
		else $error("user fault function did not latch fault");
	fault_hold_a: assert property (
		fault_active_q && !(reg_wr && reg_addr == `VIOM_A_FAULT &&
		reg_wdata[0]) |=> fault_active_q)
		else $error("fault dropped without software clear");
	fault_clear_a: assert property (
		reg_wr && reg_addr == `VIOM_A_FAULT && reg_wdata[0] &&
		!$rose(di_function_active_q[44]) |=> !fault_active_q)
		else $error("fault not cleared by software");
	init_gate_a: assert property (
		!init_done |=> !forward_run_q)
		else $error("forward run before initialisation done");
	rdata_hold_a: assert property (
		!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data changed without a read");
	unmapped_rd_a: assert property (
		reg_rd && (reg_addr > 8'h24 || (reg_addr > 8'h15 &&
		reg_addr < 8'h20)) |=> reg_rdata_q == 32'h0)
		else $error("unmapped read returned nonzero");
	func_range_a: assert property (
		reg_rd && reg_addr < 8'h0A && reg_addr != 8'h05 &&
		reg_addr != 8'h06 |=> reg_rdata_q <= 32'h3B)
		else $error("input function code above 59");
	delay_range_a: assert property (
		reg_rd && reg_addr >= 8'h10 && reg_addr < 8'h15
		|=> reg_rdata_q <= 32'h8CA0)
		else $error("output delay above limit");
endmodule

bind viom_top viom_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
	.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q), .init_done(init_done),
	.di_function_active_q(di_function_active_q),
	.forward_run_q(forward_run_q), .fault_active_q(fault_active_q),
	.fault_code_q(fault_code_q));

// ===== sim/viom_partner.sv
// Stand-in for the drive dispatcher: finishes initialisation a while
// after reset and reports output function states to the mapper.
// Assumes the bench names which output functions are asserted.
`timescale 1ns/1ps

module viom_partner #(
	parameter INIT_CYCLES = 60
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        reset,
	// Bench requests and run state
	input  wire [40:0] do_req,
	input  wire        forward_run_q,
	// Toward the mapper
	output reg         init_done,
	output reg  [40:0] do_function_state
);
	reg [7:0] cnt_q; // Startup count, saturates

	// Init finishes late so the mapper is configured first
	always @(posedge core_clk) begin
		if (reset) begin
			cnt_q <= 8'h00;
			init_done <= 1'b0;
			do_function_state <= 41'h0;
		end else begin
			if (cnt_q != INIT_CYCLES)
				cnt_q <= cnt_q + 8'h01;
			init_done <= (cnt_q == INIT_CYCLES);
			// Code 1 reports running, as a real dispatcher would
			do_function_state <= do_req | {39'h0, forward_run_q, 1'b0};
		end
	end
endmodule

// ===== sim/viom_tb_top.sv
// Self-checking bench for the virtual I/O mapper.
// Assumes the design with a short tick and the dispatcher stand-in.
`timescale 1ns/1ps
`include "viom_defines.vh"

module viom_tb_top;
	localparam TICK = 4; // Short 0.1 s tick for simulation
	logic               core_clk = 1'b0;
	logic               reset = 1'b1;
	logic [7:0]         reg_addr = 8'h00;
	logic [31:0]        reg_wdata = 32'h0;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [31:0]        reg_rdata_q;
	logic [4:0]         phys = 5'h00;
	logic signed [15:0] ain1 = 16'h0000;
	logic signed [15:0] ain2 = 16'h0000;
	logic signed [15:0] ain3 = 16'h0000;
	logic [40:0]        do_req = 41'h0;
	logic [40:0]        do_state;
	logic [59:0]        di;
	logic               init_done, run, flt;
	logic [7:0]         fcode;
	logic [4:0]         vout;
	int                 n_fail = 0;
	int                 total_checks = 0;
	int                 cycles = 0;

	always #12.5 core_clk = ~core_clk;

	viom_top #(.TICK_CYCLES(TICK)) DUT (
		.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .physical_input_n(phys),
		.analog_in_one(ain1), .analog_in_two(ain2),
		.analog_in_three(ain3), .init_done(init_done),
		.do_function_state(do_state), .di_function_active_q(di),
		.forward_run_q(run), .fault_active_q(flt),
		.fault_code_q(fcode), .virtual_output_q(vout));

	viom_partner #(.INIT_CYCLES(60)) u_partner (
		.core_clk(core_clk), .reset(reset), .do_req(do_req),
		.forward_run_q(run), .init_done(init_done),
		.do_function_state(do_state));

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Hang guard: whole run needs well under this
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail = n_fail + 1;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Writes leave one idle cycle so a strobe never flips twice at once
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a,
			input logic [31:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, e, reg_rdata_q);
		@(posedge core_clk);
	endtask

	task automatic t_regs();
		rdc("vin func rst", `VIOM_A_VIN_FUNC0, 32'h0);
		rdc("limit rst", `VIOM_A_AIN1_LIMIT, 32'h2710);
		wr(`VIOM_A_VIN_FUNC0, 32'h3C);
		rdc("vin func 60", `VIOM_A_VIN_FUNC0, 32'h0);
		wr(8'h09, 32'h3B);
		rdc("ain func 59", 8'h09, 32'h3B);
		wr(`VIOM_A_VOUT_FUNC0, 32'h29);
		rdc("vout func 41", `VIOM_A_VOUT_FUNC0, 32'h0);
		rdc("unmapped", 8'h30, 32'h0);
		rdc("src rst", `VIOM_A_VIN_SRC, 32'h0);
	endtask

	// Forced forward run, held off until init completes
	task automatic t_run();
		int i;
		wr(`VIOM_A_VIN_FUNC0, 32'h1);
		wr(`VIOM_A_VIN_SRC, 32'h1);
		wr(`VIOM_A_VIN_FORCE, 32'h1);
		wr(`VIOM_A_CMD_SRC, 32'h1);
		wr(`VIOM_A_START_PROT, 32'h0);
		chk("init pending", 1'b0, init_done);
		chk("run pre init", 1'b0, run);
		for (i = 0; i < 200 && init_done !== 1'b1; i++)
			cyc(1);
		cyc(4);
		chk("run post init", 1'b1, run);
		chk("fwd active", 1'b1, di[1]);
		wr(`VIOM_A_VIN_FORCE, 32'h0);
		cyc(4);
		chk("forced off", 1'b0, di[1]);
		chk("run off", 1'b0, run);
		wr(`VIOM_A_VIN_FORCE, 32'h1);
		cyc(4);
		rdc("status", `VIOM_A_STATUS, 32'h02000001);
		wr(`VIOM_A_CMD_SRC, 32'h0);
		cyc(3);
		chk("cmd src off", 1'b0, run);
		wr(`VIOM_A_CMD_SRC, 32'h1);
		cyc(3);
	endtask

	// Analog one over limit -> output 2 -> bound input 2 -> fault
	task automatic t_fault();
		wr(8'h01, 32'h2C);
		wr(8'h0C, 32'h1F);
		ain1 <= 16'h2710;
		cyc(8);
		chk("limit equal", 1'b0, vout[1]);
		ain1 <= 16'h2711;
		cyc(8);
		chk("limit over", 1'b1, vout[1]);
		chk("fault set", 1'b1, flt);
		chk("fault code", 8'h1B, fcode);
		chk("run stopped", 1'b0, run);
		rdc("fault reg", `VIOM_A_FAULT, 32'h1B);
		ain1 <= 16'h0000;
		cyc(8);
		chk("fault held", 1'b1, flt);
		wr(`VIOM_A_FAULT, 32'h1);
		cyc(3);
		chk("fault clear", 1'b0, flt);
		chk("run again", 1'b1, run);
		wr(8'h01, 32'h0);
		wr(8'h0C, 32'h0);
	endtask

	// Thresholds 7000 and 3000 mV with hysteresis, then polarity
	task automatic t_analog();
		logic signed [15:0] s [5] = '{16'h1B58, 16'h0BB9, 16'h0BB8,
			16'h1B57, 16'h1B58};
		logic e [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		wr(8'h08, 32'h14);
		for (int k = 0; k < 5; k++) begin
			ain2 <= s[k];
			cyc(4);
			chk("ain level", e[k], di[20]);
		end
		wr(`VIOM_A_AIN_POL, 32'h2);
		cyc(4);
		chk("low active hi", 1'b0, di[20]);
		ain2 <= 16'h0BB8;
		cyc(4);
		chk("low active lo", 1'b1, di[20]);
		wr(`VIOM_A_AIN_POL, 32'h0);
	endtask

	task automatic t_vout();
		phys <= 5'h15;
		cyc(4);
		chk("mirror", 5'h15, vout);
		wr(`VIOM_A_VOUT_SEL, 32'h3);
		cyc(4);
		chk("state sel", 5'h16, vout);
		wr(`VIOM_A_VOUT_SEL, 32'h0);
		wr(8'h02, 32'h0C);
		wr(8'h0D, 32'h05);
		do_req <= 41'h20;
		cyc(6);
		chk("func on", 1'b1, vout[2]);
		chk("bound on", 1'b1, di[12]);
		do_req <= 41'h0;
		cyc(6);
		chk("func off", 1'b0, vout[2]);
		chk("bound off", 1'b0, di[12]);
	endtask

	// Three ticks of delay on output 1, first tick may come early
	task automatic t_delay();
		int n;
		phys <= 5'h00;
		cyc(4);
		wr(`VIOM_A_VOUT_DLY0, 32'h8CA0);
		rdc("delay max", `VIOM_A_VOUT_DLY0, 32'h8CA0);
		wr(`VIOM_A_VOUT_DLY0, 32'h3);
		wr(`VIOM_A_VOUT_DLY0, 32'h8CA1);
		rdc("delay over", `VIOM_A_VOUT_DLY0, 32'h3);
		phys <= 5'h01;
		for (n = 0; n < 40 && vout[0] !== 1'b1; n++)
			cyc(1);
		chk("delay min", 1'b1, n >= 2 * TICK);
		chk("delay max", 1'b1, n <= 3 * TICK + 4);
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		t_regs();
		t_run();
		t_fault();
		t_analog();
		t_vout();
		t_delay();
		test_done();
	end
endmodule
